// *** verilog/seq_io_pkg.sv ***
/*
  constants for seq_io: codes, offsets, bits, counts.
  assumes a 25 MHz clock and an axi4-lite bus.
*/
package seq_io_pkg;
  // input function codes
  localparam logic [7:0] FN_POS_LIMIT   = 8'h07;
  localparam logic [7:0] FN_NEG_LIMIT   = 8'h08;
  localparam logic [7:0] FN_ABS_REL     = 8'h09;
  localparam logic [7:0] FN_EMG         = 8'h0a;
  localparam logic [7:0] FN_ALARM_RST   = 8'h0b;
  localparam logic [7:0] FN_SPEED_LO    = 8'h0c;
  localparam logic [7:0] FN_SPEED_HI    = 8'h0d;
  // output function codes
  localparam logic [7:0] FN_OUT_READY   = 8'h01;
  localparam logic [7:0] FN_OUT_ANY_LIM = 8'h14;
  localparam logic [7:0] FN_OUT_POS_LIM = 8'h26;
  localparam logic [7:0] FN_OUT_NEG_LIM = 8'h27;
  localparam logic [7:0] FN_OUT_EMG_DET = 8'h29;
  // register byte offsets
  localparam logic [7:0] REG_IN_MAP     = 8'h00;
  localparam logic [7:0] REG_OUT_MAP    = 8'h04;
  localparam logic [7:0] REG_CTRL       = 8'h08;
  localparam logic [7:0] REG_HOST_IN    = 8'h0c;
  localparam logic [7:0] REG_SOFT_POS   = 8'h10;
  localparam logic [7:0] REG_SOFT_NEG   = 8'h14;
  localparam logic [7:0] REG_POSITION   = 8'h18;
  localparam logic [7:0] REG_HOST_SPEED = 8'h1c;
  localparam logic [7:0] REG_STATUS     = 8'h20;
  localparam logic [7:0] REG_STORE_ATTR = 8'h24;
  localparam logic [7:0] REG_ALARM_SET  = 8'h28;
  // ctrl register bits
  localparam int CTRL_ROT_DIR    = 0;
  localparam int CTRL_SOFT_EN    = 1;
  localparam int CTRL_TORQUE_MD  = 2;
  localparam int CTRL_TOOL_RST   = 3;
  localparam int CTRL_KEY_HOLD   = 4;
  localparam int CTRL_SERVO_ON   = 5;
  // host input bits, map nibbles
  localparam int HOST_POS_LIM    = 0;
  localparam int HOST_NEG_LIM    = 1;
  localparam int HOST_ABS_REL    = 2;
  localparam int HOST_EMG        = 3;
  localparam int HOST_ALARM_RST  = 4;
  localparam int HOST_SPEED_LO   = 5;
  localparam int HOST_SPEED_HI   = 6;
  localparam int HOST_START      = 7;
  localparam int NUM_TERM        = 8;
  localparam logic [31:0] IN_MAP_RESET  = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] HOST_IN_RESET = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // key hold time for alarm clear
  localparam int CLK_HZ          = 25_000_000;
  localparam int KEY_HOLD_MS     = 1000;
  localparam int KEY_HOLD_CYC    = (CLK_HZ / 1000) * KEY_HOLD_MS;
endpackage

// *** verilog/seq_io.sv ***
/*
  sequence inputs: limits, forced stop, alarm reset,
  abs/rel latch and speed choice, behind axi4-lite.
  assumes async terminal pins and a motion core;
  one clock, sync active-low reset.
*/
// Overview of operation
// [RULE1] limit inputs take input codes 7, 8
// [RULE2] unassigned limit reads asserted, no limit
// [RULE3] terminal limit normally closed, host normally open
// [RULE4] positive limit checked by direction; blocks both
// [RULE5] outputs 38, 39, 20 show limits
// [RULE6] software limit range forces stop, flags limit
// [RULE7] opposite motion allowed to leave software limit; permits ignore CTRL_ROT_DIR, so only with it clear
// [RULE8] abs/rel latched at positioning start
// [RULE9] abs/rel only for immediate starts
// [RULE10] stored entry uses host write attribute
// [RULE11] forced stop overrides everything while deasserted
// [RULE12] host stop normally open; unassigned means run
// [RULE13] stop during motion uses third torque cap
// [RULE14] ready needs servo-on and stop input asserted
// [RULE15] stop detected output code 41
// [RULE16] position/speed mode: zero speed, ignore commands
// [RULE17] torque mode: zero torque, coast
// [RULE18] stop release needs no reset, keeps position
// [RULE19] alarm clears on rising reset edge
// [RULE20] key hold one second or tool clears
// [RULE21] two speed selects choose four speeds
// [RULE22] unassigned selects use host speed words
// [RULE23] inputs synchronised before edge detection
`timescale 1ns/100ps
`default_nettype none
module seq_io #(
  parameter int KEY_HOLD_CYC = seq_io_pkg::KEY_HOLD_CYC,
  parameter int POS_W        = 32
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          term_in,
  input  wire logic                motion_fwd,
  input  wire logic                motion_rev,
  input  wire logic                jog_fwd,
  input  wire logic                jog_rev,
  input  wire logic                start_stored,
  input  wire logic [6:0]          stored_index,
  input  wire logic [POS_W-1:0]    cur_position,
  input  wire logic                key_hold_in,
  output logic                     stop_cmd_ff,
  output logic                     zero_speed_ff,
  output logic                     zero_torque_ff,
  output logic                     torque_cap3_ff,
  output logic                     allow_fwd_ff,
  output logic                     allow_rev_ff,
  output logic                     alarm_clear_ff,
  output logic                     start_pulse_ff,
  output logic                     rel_mode_ff,
  output logic [1:0]               speed_index_ff,
  output logic                     speed_from_host_ff,
  output logic [7:0]               out_term_ff,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  logic [31:0]      in_map_ff;   // 4 bits per function slot
  logic [31:0]      out_map_ff;  // code nibble per output pin
  logic [31:0]      ctrl_ff;
  logic [31:0]      host_in_ff;
  logic [POS_W-1:0] soft_pos_ff;
  logic [POS_W-1:0] soft_neg_ff;
  logic [31:0]      host_speed_ff;
  logic             store_attr_ff;
  logic             alarm_ff;
  logic [7:0]       sync1_ff;
  logic [7:0]       sync2_ff;
  logic [7:0]       prev_ff;
  logic [31:0]      key_cnt_ff;
  logic             key_s1_ff;
  logic             key_s2_ff;
  logic             key_done_ff;
  logic [7:0]       fn_level;   // function levels
  logic [7:0]       fn_assigned;
  logic             pos_lim_hit;
  logic             neg_lim_hit;
  logic             soft_pos_hit;
  logic             soft_neg_hit;
  logic             emg_active;
  logic             aw_hold_ff;
  logic             w_hold_ff;
  logic [7:0]       aw_addr_ff;
  logic [31:0]      w_data_ff;
  logic [3:0]       w_strb_ff;
  logic             do_write;
  logic             pos_travel;
  logic             neg_travel;

  // two-flop synchroniser on terminal pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
      key_s1_ff <= 1'b0;
      key_s2_ff <= 1'b0;
    end else begin
      sync1_ff <= term_in;  // [RULE23]
      sync2_ff <= sync1_ff;
      key_s1_ff <= key_hold_in;
      key_s2_ff <= key_s1_ff;
    end
  end

  // route functions to pins (nibble = pin+1)
  always_comb begin
    logic [3:0] sel;
    logic       term_lvl;
    logic       host_lvl;
    sel = 4'h0;
    term_lvl = 1'b0;
    host_lvl = 1'b0;
    for (int f = 0; f < seq_io_pkg::NUM_TERM; f++) begin
      sel = in_map_ff[f*4 +: 4];
      host_lvl = host_in_ff[f];
      term_lvl = (sel != 4'h0) ? sync2_ff[3'(sel - 4'h1)] : 1'b0;
      fn_assigned[f] = (sel != 4'h0);
      case (f)
        seq_io_pkg::HOST_POS_LIM, seq_io_pkg::HOST_NEG_LIM,
        seq_io_pkg::HOST_EMG: begin
          // level 1 = run; terminal is nc, host is no
          if (sel == 4'h0)
            fn_level[f] = !host_lvl; // [RULE2] [RULE3] [RULE12]
          else
            fn_level[f] = term_lvl;  // [RULE1]
        end
        default:
          fn_level[f] = (sel != 4'h0) ? term_lvl : host_lvl; // [RULE9]
      endcase
    end
  end

  // direction setting flips positive sense
  assign pos_travel = ctrl_ff[seq_io_pkg::CTRL_ROT_DIR] ?
                      (motion_rev | jog_rev) : (motion_fwd | jog_fwd);
  assign neg_travel = ctrl_ff[seq_io_pkg::CTRL_ROT_DIR] ?
                      (motion_fwd | jog_fwd) : (motion_rev | jog_rev);
  assign pos_lim_hit = !fn_level[seq_io_pkg::HOST_POS_LIM];
  assign neg_lim_hit = !fn_level[seq_io_pkg::HOST_NEG_LIM];
  assign emg_active  = !fn_level[seq_io_pkg::HOST_EMG];
  assign soft_pos_hit = ctrl_ff[seq_io_pkg::CTRL_SOFT_EN] &&
                        ($signed(cur_position) > $signed(soft_pos_ff));
  assign soft_neg_hit = ctrl_ff[seq_io_pkg::CTRL_SOFT_EN] &&
                        ($signed(cur_position) < $signed(soft_neg_ff));

  // stop and permits; forced stop wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_cmd_ff    <= 1'b1;
      zero_speed_ff  <= 1'b0;
      zero_torque_ff <= 1'b0;
      torque_cap3_ff <= 1'b0;
      allow_fwd_ff   <= 1'b0;
      allow_rev_ff   <= 1'b0;
    end else begin
      zero_speed_ff  <= emg_active &&
                        !ctrl_ff[seq_io_pkg::CTRL_TORQUE_MD]; // [RULE16]
      zero_torque_ff <= emg_active &&
                        ctrl_ff[seq_io_pkg::CTRL_TORQUE_MD];  // [RULE17]
      // third cap while stop or limit active
      torque_cap3_ff <= emg_active || pos_lim_hit || neg_lim_hit; // [RULE13]
      if (emg_active) begin
        stop_cmd_ff  <= 1'b1;  // [RULE11]
        allow_fwd_ff <= 1'b0;
        allow_rev_ff <= 1'b0;
      end else if (pos_lim_hit && neg_travel) begin
        // positive limit seen during negative travel: lock both ways
        stop_cmd_ff  <= 1'b1;  // [RULE4]
        allow_fwd_ff <= 1'b0;
        allow_rev_ff <= 1'b0;
      end else begin
        // released stop resumes with no alarm reset [RULE18]
        stop_cmd_ff  <= (pos_lim_hit && pos_travel) ||
                        (neg_lim_hit && neg_travel) ||
                        (soft_pos_hit && pos_travel) ||
                        (soft_neg_hit && neg_travel); // [RULE6]
        allow_fwd_ff <= !(pos_lim_hit || soft_pos_hit); // [RULE7]
        allow_rev_ff <= !(neg_lim_hit || soft_neg_hit); // [RULE7]
      end
    end
  end

  // start pulse, abs/rel latch and speed choice
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_ff            <= 8'h00;
      start_pulse_ff     <= 1'b0;
      rel_mode_ff        <= 1'b0;
      speed_index_ff     <= 2'h0;
      speed_from_host_ff <= 1'b0;
    end else begin
      prev_ff <= fn_level;
      start_pulse_ff <= (fn_level[seq_io_pkg::HOST_START] &&
                         !prev_ff[seq_io_pkg::HOST_START]) ||
                        start_stored;
      if (start_stored && stored_index != 7'h00) begin
        rel_mode_ff <= store_attr_ff;  // [RULE10]
      end else if (fn_level[seq_io_pkg::HOST_START] &&
                   !prev_ff[seq_io_pkg::HOST_START]) begin
        rel_mode_ff <= fn_level[seq_io_pkg::HOST_ABS_REL]; // [RULE8]
        speed_index_ff <= {fn_level[seq_io_pkg::HOST_SPEED_HI],
                           fn_level[seq_io_pkg::HOST_SPEED_LO]}; // [RULE21]
        speed_from_host_ff <= !(fn_assigned[seq_io_pkg::HOST_SPEED_LO] ||
                              fn_assigned[seq_io_pkg::HOST_SPEED_HI]); // [RULE22]
      end
    end
  end

  // key hold counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_cnt_ff  <= 32'h0000_0000;
      key_done_ff <= 1'b0;
    end else if (!key_s2_ff) begin
      key_cnt_ff  <= 32'h0000_0000;
      key_done_ff <= 1'b0;
    end else if (key_cnt_ff == 32'(KEY_HOLD_CYC - 1)) begin
      key_done_ff <= 1'b1;  // [RULE20]
    end else begin
      key_cnt_ff <= key_cnt_ff + 32'h0000_0001;
    end
  end

  // alarm flag: set wins over the clear paths
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_ff       <= 1'b0;
      alarm_clear_ff <= 1'b0;
    end else begin
      alarm_clear_ff <= (fn_level[seq_io_pkg::HOST_ALARM_RST] &&
                         !prev_ff[seq_io_pkg::HOST_ALARM_RST]) ||
                        (!key_done_ff &&
                         key_cnt_ff == 32'(KEY_HOLD_CYC - 1)) ||
                        (do_write && aw_addr_ff == seq_io_pkg::REG_CTRL &&
                         w_data_ff[seq_io_pkg::CTRL_TOOL_RST]); // [RULE19]
      if (do_write && aw_addr_ff == seq_io_pkg::REG_ALARM_SET)
        alarm_ff <= 1'b1;
      else if (alarm_clear_ff)
        alarm_ff <= 1'b0;  // [RULE20]
    end
  end

  // output pins pick a status by code
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_term_ff <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        case (out_map_ff[i*4 +: 4])
          4'h1: out_term_ff[i] <= ctrl_ff[seq_io_pkg::CTRL_SERVO_ON] &&
                                  !emg_active;      // [RULE14]
          4'h2: out_term_ff[i] <= pos_lim_hit;       // [RULE5]
          4'h3: out_term_ff[i] <= neg_lim_hit;       // [RULE5]
          4'h4: out_term_ff[i] <= pos_lim_hit || neg_lim_hit ||
                                  soft_pos_hit || soft_neg_hit; // [RULE5]
          4'h5: out_term_ff[i] <= emg_active;        // [RULE15]
          4'h6: out_term_ff[i] <= alarm_ff;
          default: out_term_ff[i] <= 1'b0;
        endcase
      end
    end
  end

  // axi write channel: address and data in either order
  assign do_write = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff    <= 1'b0;
      w_hold_ff     <= 1'b0;
      aw_addr_ff    <= 8'h00;
      w_data_ff     <= 32'h0000_0000;
      w_strb_ff     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= seq_io_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_ff   <= 1'b0;
        w_hold_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_ff > seq_io_pkg::REG_ALARM_SET ||
                         aw_addr_ff == seq_io_pkg::REG_STATUS ||
                         aw_addr_ff == seq_io_pkg::REG_POSITION) ?
                        seq_io_pkg::RESP_SLVERR : seq_io_pkg::RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register storage; strobes honoured per byte lane
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_map_ff     <= seq_io_pkg::IN_MAP_RESET;
      out_map_ff    <= 32'h0000_0000;
      ctrl_ff       <= seq_io_pkg::CTRL_RESET;
      host_in_ff    <= seq_io_pkg::HOST_IN_RESET;
      soft_pos_ff   <= '0;
      soft_neg_ff   <= '0;
      host_speed_ff <= 32'h0000_0000;
      store_attr_ff <= 1'b0;
    end else if (do_write) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_ff[b]) begin
          case (aw_addr_ff)
            seq_io_pkg::REG_IN_MAP:  in_map_ff[b*8 +: 8]  <= w_data_ff[b*8 +: 8];
            seq_io_pkg::REG_OUT_MAP: out_map_ff[b*8 +: 8] <= w_data_ff[b*8 +: 8];
            seq_io_pkg::REG_CTRL:    ctrl_ff[b*8 +: 8]    <= w_data_ff[b*8 +: 8];
            seq_io_pkg::REG_HOST_IN: host_in_ff[b*8 +: 8] <= w_data_ff[b*8 +: 8];
            seq_io_pkg::REG_SOFT_POS: soft_pos_ff[b*8 +: 8] <= w_data_ff[b*8 +: 8];
            seq_io_pkg::REG_SOFT_NEG: soft_neg_ff[b*8 +: 8] <= w_data_ff[b*8 +: 8];
            seq_io_pkg::REG_HOST_SPEED:
              host_speed_ff[b*8 +: 8] <= w_data_ff[b*8 +: 8];
            seq_io_pkg::REG_STORE_ATTR:
              if (b == 0) store_attr_ff <= w_data_ff[0]; // [RULE10]
            default: ;
          endcase
        end
      end
    end
  end

  // axi read channel, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= seq_io_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= seq_io_pkg::RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'b00})
          seq_io_pkg::REG_IN_MAP:     s_axi_rdata <= in_map_ff;
          seq_io_pkg::REG_OUT_MAP:    s_axi_rdata <= out_map_ff;
          seq_io_pkg::REG_CTRL:       s_axi_rdata <= ctrl_ff;
          seq_io_pkg::REG_HOST_IN:    s_axi_rdata <= host_in_ff;
          seq_io_pkg::REG_SOFT_POS:   s_axi_rdata <= 32'(soft_pos_ff);
          seq_io_pkg::REG_SOFT_NEG:   s_axi_rdata <= 32'(soft_neg_ff);
          seq_io_pkg::REG_POSITION:   s_axi_rdata <= 32'(cur_position);
          seq_io_pkg::REG_HOST_SPEED: s_axi_rdata <= host_speed_ff;
          seq_io_pkg::REG_STATUS:
            s_axi_rdata <= {22'h0, alarm_ff, stop_cmd_ff, fn_level};
          seq_io_pkg::REG_STORE_ATTR: s_axi_rdata <= {31'h0, store_attr_ff};
          seq_io_pkg::REG_ALARM_SET:  s_axi_rdata <= {31'h0, alarm_ff};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= seq_io_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // seq_io
`default_nettype wire

// *** testbench/seq_io_checker.sv ***
/*
  assertions on seq_io ports: stop, pulses, reads.
  assumes a bind onto seq_io and sync active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module seq_io_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        stop_cmd_ff,
  input wire logic        zero_speed_ff,
  input wire logic        zero_torque_ff,
  input wire logic        torque_cap3_ff,
  input wire logic        allow_fwd_ff,
  input wire logic        allow_rev_ff,
  input wire logic        alarm_clear_ff,
  input wire logic        start_pulse_ff,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // forced stop carries the stop command
  property p_zero_stop;
    (zero_speed_ff || zero_torque_ff) |-> stop_cmd_ff;
  endproperty
  a_zero_stop: assert property (p_zero_stop) else $error("no stop");
  property p_cap3;
    zero_speed_ff |-> torque_cap3_ff;
  endproperty
  a_cap3: assert property (p_cap3) else $error("no torque cap");
  property p_no_rot;
    zero_speed_ff |-> !allow_fwd_ff && !allow_rev_ff;
  endproperty
  a_no_rot: assert property (p_no_rot) else $error("rotation allowed");
  property p_mode_excl;
    zero_torque_ff |-> !zero_speed_ff;
  endproperty
  a_mode_excl: assert property (p_mode_excl) else $error("both modes");
  // action pulses last one cycle
  property p_clr_pulse;
    $rose(alarm_clear_ff) |=> !alarm_clear_ff;
  endproperty
  a_clr_pulse: assert property (p_clr_pulse) else $error("long clear");
  property p_start_pulse;
    start_pulse_ff |=> !start_pulse_ff;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("long start");
  // read answer next cycle, then held
  property p_r_next;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_next: assert property (p_r_next) else $error("late read");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read dropped");
endmodule // seq_io_checker
`default_nettype wire

// *** testbench/field_panel.sv ***
/*
  far side: switches, stop button, motion controller.
  assumes the bench sets contacts; no bounce.
*/
`timescale 1ns/100ps
`default_nettype none
module field_panel (
  input  wire logic       aclk,
  input  wire logic [7:0] contact,
  input  wire logic       want_fwd,
  input  wire logic       want_rev,
  input  wire logic       allow_fwd,
  input  wire logic       allow_rev,
  output logic [7:0]      term_in,
  output logic            motion_fwd,
  output logic            motion_rev
);
  // closed contact drives pin high
  always_ff @(posedge aclk) begin
    term_in <= contact;
  end
  // moves only where allowed: recovery is opposite sense
  always_ff @(posedge aclk) begin
    motion_fwd <= want_fwd && allow_fwd;
    motion_rev <= want_rev && allow_rev;
  end
endmodule // field_panel
`default_nettype wire

// *** testbench/tb.sv ***
/*
  bench for seq_io: axi4-lite master, register model, checks.
  assumes field_panel drives pins; key hold cut to 20 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        aclk, aresetn, want_fwd, want_rev, jog_fwd, jog_rev, sto;
  logic        key, mfwd, mrev, awv, wv, br, arv, rr, awr, wrr, bv, arr;
  logic        rv, stop, zspd, ztrq, cap3, afwd, arev, aclr, spls, rel;
  logic        shost;
  logic [1:0]  spd, bresp, rresp, ok, err;
  logic [3:0]  strb;
  logic [6:0]  idx;
  logic [7:0]  contact, term, outt, awa, ara;
  logic [31:0] pos, wd, rdat;
  logic [31:0] st;
  int          n_fail, n_compared, cyc, n_clr, n_st;
  logic [31:0] model [int];
  assign st = {27'h0, stop, zspd, ztrq, afwd, arev};
  seq_io #(.KEY_HOLD_CYC(20)) seq_io_i (.*, .term_in(term),
    .motion_fwd(mfwd), .motion_rev(mrev), .start_stored(sto),
    .stored_index(idx),
    .cur_position(pos), .key_hold_in(key), .stop_cmd_ff(stop),
    .zero_speed_ff(zspd), .zero_torque_ff(ztrq), .torque_cap3_ff(cap3),
    .allow_fwd_ff(afwd), .allow_rev_ff(arev), .alarm_clear_ff(aclr),
    .start_pulse_ff(spls), .rel_mode_ff(rel), .speed_index_ff(spd),
    .speed_from_host_ff(shost), .out_term_ff(outt), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wrr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr));
  field_panel field_panel_i (.*, .allow_fwd(afwd), .allow_rev(arev),
    .term_in(term), .motion_fwd(mfwd), .motion_rev(mrev));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // timeout and pulse counters
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    n_clr <= n_clr + int'(aclr === 1'b1);
    n_st <= n_st + int'(spls === 1'b1);
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] a);
    n_compared++;
    if (a !== e) begin
      n_fail++;
      $display("Error at %0t: expected %h got %h", $time, e, a);
    end
  endtask
  task automatic settle();
    repeat (8) @(posedge aclk);
  endtask
  // write: aw and w together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic fa, fw;
    fa = 1'b0;
    fw = 1'b0;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(fa && fw)) begin
      @(posedge aclk);
      if (awr && !fa) begin
        fa = 1'b1;
        awv <= 1'b0;
      end
      if (wrr && !fw) begin
        fw = 1'b1;
        wv <= 1'b0;
      end
    end
    br <= 1'b1;
    do @(posedge aclk); while (!bv);
    br <= 1'b0;
    chk(32'(er), 32'(bresp));
    if (er === ok) model[a] = d;
  endtask
  // read: rready late so the slave must hold
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    do @(posedge aclk); while (!arr);
    arv <= 1'b0;
    @(posedge aclk);
    rr <= 1'b1;
    do @(posedge aclk); while (!rv);
    rr <= 1'b0;
    chk(e, rdat);
    chk(32'(er), 32'(rresp));
  endtask
  task automatic hin(input logic [31:0] v);
    wr(seq_io_pkg::REG_HOST_IN, v, ok);
    settle();
  endtask
  task automatic ctl(input logic [31:0] v);
    wr(seq_io_pkg::REG_CTRL, v, ok);
    settle();
  endtask
  initial begin
    {aresetn, want_fwd, want_rev, jog_fwd, jog_rev, sto, key} = '0;
    {awv, wv, br, arv, rr, awa, ara, wd, idx, pos} = '0;
    strb = 4'hf;
    contact = 8'hff;
    ok = seq_io_pkg::RESP_OKAY;
    err = seq_io_pkg::RESP_SLVERR;
    void'($urandom(32'h240d));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(seq_io_pkg::REG_IN_MAP, seq_io_pkg::IN_MAP_RESET, ok);
    rdchk(seq_io_pkg::REG_CTRL, seq_io_pkg::CTRL_RESET, ok);
    rdchk(seq_io_pkg::REG_HOST_IN, seq_io_pkg::HOST_IN_RESET, ok);
    rdchk(8'h30, 32'h0, err);
    wr(seq_io_pkg::REG_STATUS, 32'hffff_ffff, err);
    settle();
    chk(32'h03, st);
    $display("test reset done");
    hin(32'h1 << seq_io_pkg::HOST_EMG);
    chk(32'h18, st);
    ctl(32'h1 << seq_io_pkg::CTRL_TORQUE_MD);
    chk(32'h14, st);
    hin(32'h0);
    chk(32'h03, st);
    wr(seq_io_pkg::REG_IN_MAP, 32'h0000_3021, ok);
    wr(seq_io_pkg::REG_OUT_MAP, 32'h0005_4321, ok);
    ctl(32'h1 << seq_io_pkg::CTRL_SERVO_ON);
    chk(32'h01, 32'(outt));
    contact <= 8'hfb;
    settle();
    chk(32'h10, 32'(outt));
    chk(32'h18, st);
    contact <= 8'hfe;
    settle();
    chk(32'h0a, 32'(outt & 8'h0e));
    chk(32'h0, 32'(afwd));
    contact <= 8'hfc;
    settle();
    chk(32'h0e, 32'(outt & 8'h0e));
    contact <= 8'hff;
    wr(seq_io_pkg::REG_IN_MAP, 32'h0000_3000, ok);
    hin(32'h1 << seq_io_pkg::HOST_NEG_LIM);
    chk(32'h0c, 32'(outt & 8'h0e));
    hin(32'h0);
    $display("test stop and limits done");
    wr(seq_io_pkg::REG_SOFT_POS, 32'd100, ok);
    wr(seq_io_pkg::REG_SOFT_NEG, 32'hffff_ff9c, ok);
    rdchk(seq_io_pkg::REG_SOFT_POS, model[seq_io_pkg::REG_SOFT_POS], ok);
    ctl(32'h22);
    want_fwd <= 1'b1;
    want_rev <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      pos <= 32'($urandom_range(198)) - 32'd99;
      settle();
      chk(32'h0, 32'(outt & 8'h08));
    end
    pos <= 32'd150;
    settle();
    chk(32'h08, 32'(outt & 8'h08));
    chk(32'h1, 32'({afwd, arev}));
    pos <= -32'sd150;
    settle();
    chk(32'h2, 32'({afwd, arev}));
    ctl(32'h20);
    chk(32'h0, 32'(outt & 8'h08));
    pos <= 32'h0;
    $display("test soft limit done");
    wr(seq_io_pkg::REG_IN_MAP, 32'h0, ok);
    wr(seq_io_pkg::REG_STORE_ATTR, 32'h0, ok);
    hin(32'h84);
    chk(32'h1, 32'(rel));
    hin(32'h80);
    chk(32'h1, 32'(rel));
    hin(32'h4);
    for (int i = 0; i < 2; i++) begin
      wr(seq_io_pkg::REG_STORE_ATTR, 32'(i), ok);
      idx <= 7'($urandom_range(99, 1));
      sto <= 1'b1;
      @(posedge aclk);
      sto <= 1'b0;
      settle();
      chk(32'(i), 32'(rel));
    end
    hin(32'h0);
    chk(32'd3, 32'(n_st));
    $display("test abs rel done");
    wr(seq_io_pkg::REG_IN_MAP, 32'h0760_0000, ok);
    for (int i = 0; i < 4; i++) begin
      contact <= {1'b1, i[1], i[0], 5'h1f};
      settle();
      hin(32'h80);
      chk(32'(i), 32'(spd));
      chk(32'h0, 32'(shost));
      hin(32'h0);
    end
    wr(seq_io_pkg::REG_IN_MAP, 32'h0, ok);
    hin(32'h80);
    chk(32'h1, 32'(shost));
    hin(32'h0);
    $display("test speed done");
    for (int m = 0; m < 3; m++) begin
      wr(seq_io_pkg::REG_ALARM_SET, 32'h1, ok);
      rdchk(seq_io_pkg::REG_ALARM_SET, 32'h1, ok);
      if (m == 0) hin(32'h10);
      if (m == 1) ctl(32'h08);
      key <= (m == 2);
      repeat (40) @(posedge aclk);
      key <= 1'b0;
      hin(32'h0);
      chk(32'(m + 1), 32'(n_clr));
      rdchk(seq_io_pkg::REG_ALARM_SET, 32'h0, ok);
    end
    $display("test alarm done");
    final_report();
  end
endmodule // tb
bind seq_io seq_io_checker seq_io_checker_i (.*);
`default_nettype wire
